// ===== logic/sarc_regs.svh
// Constants for the converter range-check scan port
`ifndef SARC_REGS_SVH
`define SARC_REGS_SVH

// Scan chain layout, bit 0 shifted first
`define SARC_CHAIN_LEN   38
`define SARC_B_VREF      0
`define SARC_B_SETTLE    1
`define SARC_B_SWITCHCAP_TEST_ENABLE    2
`define SARC_B_LATCH_PRECHARGE_N_N   3
`define SARC_B_GAIN_PASSGATE_ENABLE    4
`define SARC_B_NEG       5
`define SARC_B_MUX       8
`define SARC_B_IREF      16
`define SARC_B_HOLD      17
`define SARC_B_GND       18
`define SARC_B_G20       19
`define SARC_B_G10       20
`define SARC_B_EXTCH     21
`define SARC_B_DAC       22
`define SARC_B_AMPLIFIER_POWER_ON     32
`define SARC_B_CONVERTER_POWER_ON     33
`define SARC_B_COMP      34
`define SARC_B_PIN_VAL   35
`define SARC_B_PIN_DIR   36
`define SARC_B_PIN_PULL  37

// Idle cell values and test values
`define SARC_IDLE_ROW    38'h0080220118
`define SARC_DAC_MID     10'h200
`define SARC_CHANNEL     8'h08

// Instruction register
`define SARC_IR_LEN      2
`define SARC_IR_EXTEST   2'h0
`define SARC_IR_PRELOAD  2'h1
`define SARC_IR_CAPTURE  2'h1

// Timing
`define SARC_CLK_NS      20
`define SARC_TCK_HALF    4'h8
`define SARC_EN_WAIT_NS  200
`define SARC_EN_WAIT_CYC ((`SARC_EN_WAIT_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
`define SARC_DUMMY_CMP   4'hA

// Controller register port
`define SARC_REG_CTRL    2'h0
`define SARC_REG_LIMITS  2'h1
`define SARC_REG_STATUS  2'h2
`define SARC_CTRL_START  0
`define SARC_LIM_LO      0
`define SARC_LIM_HI      16
`define SARC_ST_BUSY     0
`define SARC_ST_DONE     1
`define SARC_ST_LOW_OK   2
`define SARC_ST_HIGH_OK  3
`define SARC_ST_PASS     4

`endif

// ===== logic/sarc_pkg.sv
// Types shared by both ends of the range-check scan link
package sarc_pkg;
    typedef logic [37:0] sarc_chain_t;
    typedef logic [1:0]  sarc_instr_t;
    typedef enum logic [2:0] {
        SARC_IDLE,
        SARC_LOW,
        SARC_HIGH,
        SARC_TAIL,
        SARC_SETTLE
    } sarc_state_t;
endpackage

// ===== logic/sarc_link_if.sv
// Scan link between test controller and converter scan cells
`timescale 1ns/1ps
interface sarc_link_if;
    logic tck;
    logic tms;
    logic tdi;
    logic ir_sel;
    logic tdo;
    modport ctrl (output tck, output tms, output tdi, output ir_sel, input tdo);
    modport dev  (input tck, input tms, input tdi, input ir_sel, output tdo);
endinterface

// ===== logic/sarc_scan_dev.sv
// Converter front-end scan cells, device end of the link
`timescale 1ns/1ps
`include "sarc_regs.svh"
module sarc_scan_dev
    import sarc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    sarc_link_if.dev        link,
    input  wire logic       comparator_i,
    input  wire logic       func_power_on_i,
    output logic [7:0]      input_channel_select_o,
    output logic [2:0]      negative_input_select_o,
    output logic            gain_passgate_enable_o,
    output logic            latch_precharge_n_o,
    output logic            switchcap_test_enable_o,
    output logic            settle_assist_o,
    output logic            supply_reference_select_o,
    output logic            converter_power_on_o,
    output logic            amplifier_power_on_o,
    output logic            sample_hold_o,
    output logic [9:0]      comparison_value_o,
    output logic            bandgap_ref_enable_o,
    output logic            ground_negative_o,
    output logic            gain10_enable_o,
    output logic            gain20_enable_o,
    output logic            bypass_enable_o,
    output logic            channel3_pin_value_o,
    output logic            channel3_pin_direction_o,
    output logic            channel3_pin_pullup_o,
    output logic            dummy_busy_o
);
    logic [4:0]  sync1;
    logic [4:0]  sync2;
    logic        tck_d;
    logic        tms_d;
    logic        ir_mode;
    sarc_instr_t instr;
    sarc_instr_t ir_shift;
    sarc_chain_t dr_shift;
    sarc_chain_t upd;
    sarc_chain_t drv;
    logic        pwr_d;
    logic [3:0]  dummy_cnt;

    wire [4:0] raw_in = {comparator_i, link.ir_sel, link.tdi, link.tms, link.tck};

    // Pins come from other domains
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_sync
            always_ff @(posedge clk_i or posedge reset_i) begin
                if (reset_i) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= raw_in[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    wire tck_rise = sync2[0] & ~tck_d;
    wire tms_rise = sync2[1] & ~tms_d;
    wire tms_fall = ~sync2[1] & tms_d;
    wire extest   = (instr == `SARC_IR_EXTEST);

    // Comparator cell observes the live result; others read back their update cells
    wire sarc_chain_t capture_row = {upd[37:35], sync2[4], upd[33:0]};
    wire sarc_chain_t normal_row  = {`SARC_IDLE_ROW} | ({37'h0, func_power_on_i} << `SARC_B_CONVERTER_POWER_ON);
    wire sarc_chain_t next_drv    = extest ? upd : normal_row;
    wire              pwr_rise    = drv[`SARC_B_CONVERTER_POWER_ON] & ~pwr_d;

    assign link.tdo = ir_mode ? ir_shift[0] : dr_shift[0];

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tck_d    <= 1'b0;
            tms_d    <= 1'b0;
            ir_mode  <= 1'b0;
            instr    <= `SARC_IR_PRELOAD;
            ir_shift <= '0;
            dr_shift <= '0;
            upd      <= `SARC_IDLE_ROW;
        end else begin
            tck_d <= sync2[0];
            tms_d <= sync2[1];
            if (tms_rise) begin
                ir_mode  <= sync2[3];
                ir_shift <= `SARC_IR_CAPTURE;
                dr_shift <= capture_row;
            end else if (tms_fall) begin
                // Preload and test both load the update cells; only test drives them
                if (ir_mode) instr <= ir_shift;
                else upd <= dr_shift;
            end else if (tck_rise && sync2[1]) begin
                if (ir_mode) ir_shift <= {sync2[2], ir_shift[1]};
                else dr_shift <= {sync2[2], dr_shift[37:1]};
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            drv       <= `SARC_IDLE_ROW;
            pwr_d     <= 1'b0;
            dummy_cnt <= 4'h0;
        end else begin
            drv   <= next_drv;
            pwr_d <= drv[`SARC_B_CONVERTER_POWER_ON];
            if (pwr_rise && !extest) dummy_cnt <= `SARC_DUMMY_CMP; // R12
            else if (dummy_cnt != 4'h0) dummy_cnt <= dummy_cnt - 4'h1;
        end
    end

    assign dummy_busy_o              = (dummy_cnt != 4'h0); // R12
    assign input_channel_select_o    = drv[`SARC_B_MUX +: 8];
    assign negative_input_select_o   = drv[`SARC_B_NEG +: 3]; // R02
    assign gain_passgate_enable_o    = drv[`SARC_B_GAIN_PASSGATE_ENABLE]; // R03
    assign latch_precharge_n_o       = drv[`SARC_B_LATCH_PRECHARGE_N_N]; // R04
    assign switchcap_test_enable_o   = drv[`SARC_B_SWITCHCAP_TEST_ENABLE]; // R05
    assign settle_assist_o           = drv[`SARC_B_SETTLE];
    assign supply_reference_select_o = drv[`SARC_B_VREF]; // R07
    assign converter_power_on_o      = drv[`SARC_B_CONVERTER_POWER_ON]; // R19
    assign amplifier_power_on_o      = drv[`SARC_B_AMPLIFIER_POWER_ON];
    assign sample_hold_o             = drv[`SARC_B_HOLD]; // R18
    assign comparison_value_o        = drv[`SARC_B_DAC +: 10]; // R20
    assign bandgap_ref_enable_o      = drv[`SARC_B_IREF];
    assign ground_negative_o         = drv[`SARC_B_GND];
    assign gain10_enable_o           = drv[`SARC_B_G10];
    assign gain20_enable_o           = drv[`SARC_B_G20];
    assign bypass_enable_o           = drv[`SARC_B_EXTCH];
    assign channel3_pin_value_o      = drv[`SARC_B_PIN_VAL];
    assign channel3_pin_direction_o  = drv[`SARC_B_PIN_DIR];
    assign channel3_pin_pullup_o     = drv[`SARC_B_PIN_PULL];
endmodule

// ===== logic/sarc_scan_ctrl.sv
// Scan test controller that runs the converter range check
// What this block does
// R01 - Idle converter cells get recommended values
// R02 - Three negative-select bits form one code
// R03 - Pass-gate cell enables gain-stage pass gates
// R04 - Precharge cell active low, precharges latch
// R05 - Switch-cap test routes x10 stage out
// R06 - Settle assist stays low here
// R07 - Supply-reference cell selects supply as reference
// R08 - Exactly one negative comparator source selected
// R09 - Gain stages left off during scan
// R10 - Lower limit expects low, upper high
// R11 - Measured pin: input, pull-up off
// R12 - Enabling converter runs ten dummy comparisons; the device model runs them only outside EXTEST, not during the scan
// R13 - Wait 200 ns after enabling converter
// R14 - Midpoint comparison value while sampling
// R15 - Instruction first; check data out on rows six and eleven only
// R16 - Test clock fast enough for hold
// R17 - Preload, sample, hold, limit, precharge, read
// R18 - Hold control samples low, holds high
// R19 - Converter enable cell powers converter on
// R20 - Ten cells form comparison value, bit 9 top
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "sarc_regs.svh"
module sarc_scan_ctrl
    import sarc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic [1:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rdata_o,
    sarc_link_if.ctrl        link
);
    sarc_state_t state;
    sarc_state_t next_state;
    logic [3:0]  step;
    logic [3:0]  div_cnt;
    logic [5:0]  bit_cnt;
    logic [3:0]  wait_cnt;
    sarc_chain_t tx;
    sarc_chain_t rx;
    logic [9:0]  lower_limit;
    logic [9:0]  upper_limit;
    logic        done;
    logic        low_ok;
    logic        high_ok;
    logic        tdo_s1;
    logic        tdo_s2;
    logic        tck;
    logic        tms;
    logic        ir_sel;

    // One frame per step: 0 and 2 are instructions, 13 restores idle cells
    function automatic sarc_chain_t row_for(input logic [3:0] s,
                                            input logic [9:0] lo,
                                            input logic [9:0] hi);
        sarc_chain_t r;
        logic [3:0]  n;
        r = `SARC_IDLE_ROW; // R01 R06 R08 R09
        r[`SARC_B_MUX +: 8] = `SARC_CHANNEL; // R17
        r[`SARC_B_CONVERTER_POWER_ON] = 1'b1;
        r[`SARC_B_DAC +: 10] = `SARC_DAC_MID; // R14
        r[`SARC_B_PIN_DIR] = 1'b0; // R11
        r[`SARC_B_PIN_PULL] = 1'b0; // R11
        n = (s == 4'h1) ? 4'h1 : s - 4'h1;
        if (n == 4'h2 || n == 4'h7) r[`SARC_B_HOLD] = 1'b0; // R17
        if (n == 4'h4 || n == 4'h5) r[`SARC_B_DAC +: 10] = lo; // R10
        if (n == 4'h9 || n == 4'hA) r[`SARC_B_DAC +: 10] = hi; // R10
        if (n == 4'h5 || n == 4'hA) r[`SARC_B_LATCH_PRECHARGE_N_N] = 1'b0; // R17
        if (s == 4'hD) r = `SARC_IDLE_ROW; // R01
        return r;
    endfunction

    // Next frame is loaded as the current one ends, so look one step ahead
    wire [3:0]        load_step = (state == SARC_TAIL) ? step + 4'h1 :
                                  (state == SARC_SETTLE) ? step : 4'h0;
    wire              is_ir    = (step == 4'h0) || (step == 4'h2); // R15
    wire              load_ir  = (load_step == 4'h0) || (load_step == 4'h2); // R15
    wire sarc_instr_t step_ir  = (load_step == 4'h0) ? `SARC_IR_PRELOAD : `SARC_IR_EXTEST;
    wire sarc_chain_t step_tx  = load_ir ? {36'h0, step_ir}
                                         : row_for(load_step, lower_limit, upper_limit);
    wire [5:0]        last_bit = is_ir ? 6'd1 : 6'd37;
    wire              half_end = (div_cnt == `SARC_TCK_HALF - 4'h1); // R16
    wire              start    = wr_i && (addr_i == `SARC_REG_CTRL)
                                 && wdata_i[`SARC_CTRL_START] && (state == SARC_IDLE);
    wire              lim_wr   = wr_i && (addr_i == `SARC_REG_LIMITS) && (state == SARC_IDLE);
    wire              busy     = (state != SARC_IDLE);
    wire              wait_end = (wait_cnt == 4'(`SARC_EN_WAIT_CYC - 1));
    wire              frame_end = (state == SARC_TAIL) && half_end;
    wire [31:0]       status   = {27'h0, low_ok & high_ok, high_ok, low_ok, done, busy};
    wire [31:0]       limits   = {6'h0, upper_limit, 6'h0, lower_limit};
    wire [31:0]       next_rdata = (addr_i == `SARC_REG_STATUS) ? status :
                                   (addr_i == `SARC_REG_LIMITS) ? limits : 32'h0;

    always_comb begin
        next_state = state;
        unique case (state)
            SARC_IDLE:   if (start) next_state = SARC_LOW;
            SARC_LOW:    if (half_end) next_state = SARC_HIGH;
            SARC_HIGH:   if (half_end) next_state = (bit_cnt == last_bit) ? SARC_TAIL : SARC_LOW;
            SARC_TAIL: begin
                if (half_end) begin
                    if (step == 4'h1) next_state = SARC_SETTLE; // R13
                    else if (step == 4'hD) next_state = SARC_IDLE;
                    else next_state = SARC_LOW;
                end
            end
            SARC_SETTLE: if (wait_end) next_state = SARC_LOW; // R13
        endcase
    end

    // Link output from another domain: two flops before use
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tdo_s1 <= 1'b0;
            tdo_s2 <= 1'b0;
        end else begin
            tdo_s1 <= link.tdo;
            tdo_s2 <= tdo_s1;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state    <= SARC_IDLE;
            div_cnt  <= 4'h0;
            wait_cnt <= 4'h0;
        end else begin
            state    <= next_state;
            div_cnt  <= (state == next_state && state != SARC_IDLE) ? div_cnt + 4'h1 : 4'h0;
            wait_cnt <= (state == SARC_SETTLE) ? wait_cnt + 4'h1 : 4'h0;
        end
    end

    // Frame sequencing and shifting
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            step    <= 4'h0;
            bit_cnt <= 6'h0;
            tx      <= '0;
            rx      <= '0;
            tck     <= 1'b0;
            tms     <= 1'b0;
            ir_sel  <= 1'b0;
        end else begin
            if (start) begin
                step    <= 4'h0;
            end else if (frame_end) begin
                step    <= step + 4'h1;
            end
            if (next_state == SARC_LOW && (state == SARC_IDLE || state == SARC_TAIL
                                           || state == SARC_SETTLE)) begin
                tx      <= step_tx;
                tms     <= 1'b1;
                ir_sel  <= load_ir; // R15
                bit_cnt <= 6'h0;
            end
            if (state == SARC_LOW && half_end) begin
                tck <= 1'b1;
                rx  <= {tdo_s2, rx[37:1]};
            end
            if (state == SARC_HIGH && half_end) begin
                tck <= 1'b0;
                if (bit_cnt == last_bit) begin
                    tms <= 1'b0;
                end else begin
                    tx      <= {1'b0, tx[37:1]};
                    bit_cnt <= bit_cnt + 6'h1;
                end
            end
        end
    end

    // Check the comparator cell shifted out on rows six and eleven
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            lower_limit <= 10'h0;
            upper_limit <= 10'h0;
            done        <= 1'b0;
            low_ok      <= 1'b0;
            high_ok     <= 1'b0;
            rdata_o     <= 32'h0;
        end else begin
            rdata_o <= rd_i ? next_rdata : 32'h0;
            if (lim_wr) begin
                lower_limit <= wdata_i[`SARC_LIM_LO +: 10];
                upper_limit <= wdata_i[`SARC_LIM_HI +: 10];
            end
            if (start) begin
                done    <= 1'b0;
                low_ok  <= 1'b0;
                high_ok <= 1'b0;
            end else if (frame_end) begin
                if (step == 4'h7) low_ok <= ~rx[`SARC_B_COMP]; // R10
                if (step == 4'hC) high_ok <= rx[`SARC_B_COMP]; // R10
                if (step == 4'hD) done <= 1'b1;
            end
        end
    end

    assign link.tck    = tck;
    assign link.tms    = tms;
    assign link.tdi    = tx[0];
    assign link.ir_sel = ir_sel;
endmodule

// ===== tb/sarc_link_properties.sv
// Timing checks on the scan link between the two ends
`timescale 1ns/1ps
module sarc_link_properties (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic ir_sel,
    input wire logic tdo
);
    logic       tck_q;
    logic       tms_q;
    logic       frame_ir;
    logic [5:0] rises;

    // Counts tck rises per frame, cleared at frame start
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tck_q    <= 1'b0;
            tms_q    <= 1'b0;
            frame_ir <= 1'b0;
            rises    <= 6'h00;
        end else begin
            tck_q <= tck;
            tms_q <= tms;
            if (tms && !tms_q) begin
                frame_ir <= ir_sel;
                rises    <= 6'h00;
            end else if (tck && !tck_q) begin
                rises <= rises + 6'h01;
            end
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence high_phase;
        tck [*8] ##1 !tck;
    endsequence
    sequence low_phase;
        (!tck) [*8] ##1 tck;
    endsequence

    chk_tck_high_width: assert property ($rose(tck) |-> high_phase)
        else $error("scan clock high phase wrong length");
    chk_tck_low_width: assert property ($fell(tck) && tms |-> low_phase)
        else $error("scan clock low phase wrong length");
    chk_frame_lead_in: assert property ($rose(tms) |-> (!tck) [*8])
        else $error("scan clock started too soon in frame");
    chk_frame_gap: assert property ($fell(tms) |-> (!tms) [*8])
        else $error("frames too close together");
    chk_clock_in_frame: assert property (!tms |-> !tck)
        else $error("scan clock moved outside frame");
    chk_data_held: assert property (tck && tck_q |-> $stable({tdi, tms, ir_sel}))
        else $error("link data changed while scan clock high");
    chk_frame_length: assert property (tms_q && !tms |->
        rises == (frame_ir ? 6'h02 : 6'h26))
        else $error("wrong number of bits in frame");
    chk_kind_steady: assert property (tms && tms_q |-> $stable(ir_sel))
        else $error("frame kind changed inside frame");
    cover property (tms && tdo);
endmodule

// ===== tb/scan_adc_range_check_test.sv
// Bench driving controller registers and watching converter cells
`timescale 1ns/1ps
`include "sarc_regs.svh"
module scan_adc_range_check_test;
    logic        clk_i;
    logic        reset_i;
    logic [1:0]  addr_i;
    logic [31:0] wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [31:0] rdata_o;
    logic        comparator_i;
    logic        func_power_on_i;
    logic [7:0]  input_channel_select_o;
    logic [2:0]  negative_input_select_o;
    logic [9:0]  comparison_value_o;
    logic [9:0]  analog_level;
    logic        gain_passgate_enable_o, latch_precharge_n_o, switchcap_test_enable_o;
    logic        settle_assist_o, supply_reference_select_o, converter_power_on_o;
    logic        amplifier_power_on_o, sample_hold_o, bandgap_ref_enable_o;
    logic        ground_negative_o, gain10_enable_o, gain20_enable_o, bypass_enable_o;
    logic        channel3_pin_value_o, channel3_pin_direction_o, channel3_pin_pullup_o;
    logic        dummy_busy_o;
    logic        latch_precharge_n_q;
    int          fail_count;
    int          samples_checked;
    int          cycles;
    int          latch_precharge_n_lows;

    sarc_link_if sarc_link_if_inst ();
    sarc_scan_ctrl sarc_scan_ctrl_inst (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .link(sarc_link_if_inst));
    sarc_scan_dev sarc_scan_dev_inst (.clk_i, .reset_i, .link(sarc_link_if_inst),
        .comparator_i, .func_power_on_i, .input_channel_select_o, .negative_input_select_o,
        .gain_passgate_enable_o, .latch_precharge_n_o, .switchcap_test_enable_o,
        .settle_assist_o, .supply_reference_select_o, .converter_power_on_o,
        .amplifier_power_on_o, .sample_hold_o, .comparison_value_o, .bandgap_ref_enable_o,
        .ground_negative_o, .gain10_enable_o, .gain20_enable_o, .bypass_enable_o,
        .channel3_pin_value_o, .channel3_pin_direction_o, .channel3_pin_pullup_o,
        .dummy_busy_o);
    sarc_link_properties sarc_link_properties_inst (.clk_i, .reset_i,
        .tck(sarc_link_if_inst.tck), .tms(sarc_link_if_inst.tms),
        .tdi(sarc_link_if_inst.tdi), .ir_sel(sarc_link_if_inst.ir_sel),
        .tdo(sarc_link_if_inst.tdo));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %0h seen %0h", n, e, g);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask

    // Comparator high once the converter value reaches the input level
    always @(posedge clk_i) begin
        cycles       <= cycles + 1;
        latch_precharge_n_q      <= latch_precharge_n_o;
        comparator_i <= (comparison_value_o >= analog_level);
        if (latch_precharge_n_q && !latch_precharge_n_o) begin
            latch_precharge_n_lows <= latch_precharge_n_lows + 1;
        end
        if (!reset_i) begin
            chk("quiet cells", 32'h0, {21'h0, negative_input_select_o,
                bandgap_ref_enable_o & ground_negative_o, gain10_enable_o, gain20_enable_o,
                settle_assist_o, switchcap_test_enable_o, supply_reference_select_o,
                amplifier_power_on_o, channel3_pin_value_o});
        end
        if (!reset_i && !sample_hold_o) begin
            chk("sample value", 32'(`SARC_DAC_MID), 32'(comparison_value_o));
            chk("sample cells", 32'h420, {21'h0, converter_power_on_o, input_channel_select_o,
                channel3_pin_direction_o, channel3_pin_pullup_o});
        end
        if (cycles == 50000) begin
            fail_count++;
            results();
        end
    end

    task automatic t_idle();
        logic [31:0] d;
        chk("mux", 32'h01, 32'(input_channel_select_o));
        chk("neg", 32'h0, 32'(negative_input_select_o));
        chk("cells", 32'hF, {28'h0, gain_passgate_enable_o, latch_precharge_n_o,
            sample_hold_o, bypass_enable_o});
        chk("dac", 32'h200, 32'(comparison_value_o));
        rd(2'h3, d);
        chk("unmapped", 32'h0, d);
        rd(`SARC_REG_STATUS, d);
        chk("status", 32'h0, d);
    endtask

    task automatic t_dummy();
        int n;
        n = 0;
        @(posedge clk_i);
        func_power_on_i <= 1'b1;
        repeat (24) begin
            @(posedge clk_i);
            n = n + int'(dummy_busy_o === 1'b1);
        end
        chk("busy cycles", 32'd10, 32'(n));
        chk("power", 32'h1, 32'(converter_power_on_o));
        func_power_on_i <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    // One full range check; meddle tries writes that must be refused
    task automatic t_run(input logic [9:0] lo, input logic [9:0] hi, input logic [9:0] lvl,
                         input bit meddle, input logic [31:0] e);
        logic [31:0] d;
        int          p0;
        int          k;
        p0 = latch_precharge_n_lows;
        analog_level <= lvl;
        wr(`SARC_REG_LIMITS, {6'h00, hi, 6'h00, lo});
        wr(`SARC_REG_CTRL, 32'h1);
        rd(`SARC_REG_STATUS, d);
        chk("started", 32'h1, d);
        if (meddle) begin
            wr(`SARC_REG_LIMITS, {6'h00, 10'h3FF, 16'h0000});
            wr(`SARC_REG_CTRL, 32'h1);
        end
        for (k = 0; k < 6000 && d[1] !== 1'b1; k++) begin
            rd(`SARC_REG_STATUS, d);
        end
        chk("status", e, d);
        chk("precharge pulses", 32'd2, 32'(latch_precharge_n_lows - p0));
        chk("idle mux", 32'h01, 32'(input_channel_select_o));
        chk("idle power", 32'h0, 32'(converter_power_on_o));
    endtask

    initial begin
        reset_i         = 1'b1;
        addr_i          = 2'h0;
        wdata_i         = 32'h0;
        wr_i            = 1'b0;
        rd_i            = 1'b0;
        func_power_on_i = 1'b0;
        comparator_i    = 1'b0;
        analog_level    = 10'h130;
        latch_precharge_n_q         = 1'b1;
        fail_count      = 0;
        samples_checked = 0;
        cycles          = 0;
        latch_precharge_n_lows      = 0;
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        t_idle();
        t_dummy();
        t_run(10'h123, 10'h143, 10'h130, 1'b0, 32'h1E);
        t_run(10'h123, 10'h143, 10'h100, 1'b0, 32'h0A);
        t_run(10'h123, 10'h143, 10'h150, 1'b1, 32'h06);
        results();
    end
endmodule
